// ==== hw/atm_pkg.sv ====
// Package for the angular timer measurement register slice
package atm_pkg;

  // ****************************************************************
  // Register byte offsets on the APB bus
  // ****************************************************************
  localparam logic [7:0] ATM_OFS_DIV_HI   = 8'h00;
  localparam logic [7:0] ATM_OFS_DIV_LO   = 8'h04;
  localparam logic [7:0] ATM_OFS_MISS_HI  = 8'h08;
  localparam logic [7:0] ATM_OFS_MISS_LO  = 8'h0C;
  localparam logic [7:0] ATM_OFS_IVL_HI   = 8'h10;
  localparam logic [7:0] ATM_OFS_IVL_LO   = 8'h14;
  localparam logic [7:0] ATM_OFS_PHS_HI   = 8'h18;
  localparam logic [7:0] ATM_OFS_PHS_LO   = 8'h1C;
  localparam logic [7:0] ATM_OFS_IRQ_EN   = 8'h20;
  localparam logic [7:0] ATM_OFS_CTRL     = 8'h24;
  localparam logic [7:0] ATM_OFS_STATUS   = 8'h28;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int         ATM_BIT_PHS      = 2;
  localparam int         ATM_BIT_MISS     = 1;
  localparam int         ATM_BIT_IVL      = 0;
  localparam int         ATM_BIT_ENABLE   = 0;
  localparam int         ATM_BIT_ADAPT    = 1;
  localparam int         ATM_BIT_VALID    = 3;
  localparam logic [2:0] ATM_IRQ_EN_RST   = 3'h0;
  localparam logic [1:0] ATM_CTRL_RST     = 2'h0;
  localparam logic [1:0] ATM_VALID_EDGES  = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } atm_apb_req_t;

  typedef enum logic [1:0] {
    ATM_IDLE = 2'b01,
    ATM_ACK  = 2'b10
  } atm_bus_state_t;

endpackage : atm_pkg

// ==== hw/atm_top.sv ====
// Angular timer measurement registers, interval and phase logic
`timescale 1ns/1ps

module atm_top
#(
  parameter int IVL_W = 15,
  parameter int DIV_W = 10
) (
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               reset_i,
  // APB slave
  input  wire atm_pkg::atm_apb_req_t apb_req_i,
  output logic                    pready_o,
  output logic [31:0]             prdata_o,
  output logic                    pslverr_o,
  // Rotation pulse input
  input  wire logic               pulse_i,
  // Timer outputs
  output logic                    phase_clk_o,
  output logic                    absent_edge_o,
  output logic [2:0]              irq_o
);
  import atm_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  atm_bus_state_t     bus_q;
  logic [DIV_W-1:0]   divisor_q;
  logic [15:0]        delay_q;
  logic [IVL_W-1:0]   count_q;
  logic [IVL_W-1:0]   interval_q;
  logic               roll_run_q;
  logic               rollover_q;
  logic [DIV_W-1:0]   phase_q;
  logic [IVL_W:0]     acc_q;
  logic [1:0]         edges_q;
  logic               pulse_q;
  logic               missed_q;
  logic [2:0]         irq_en_q;
  logic [2:0]         flags_q;
  logic [1:0]         ctrl_q;
  logic               access;
  logic               wr_en;
  logic               div_wr;
  logic               edge_seen;
  logic               valid;
  logic               phase_tick;
  logic               miss_hit;
  logic [IVL_W:0]     acc_sum;
  logic [15:0]        diff;
  logic [IVL_W+1:0]   adapt_lim;
  logic [2:0]         events;
  logic [31:0]        rdata;
  logic               mapped;

  // Byte write helper: low byte of the bus word
  function automatic logic [7:0] wbyte(input logic [31:0] d);
    return d[7:0];
  endfunction : wbyte

  // ****************************************************************
  // APB slave: one wait state, answer in the access phase
  // ****************************************************************

  // Access phase sampled with ready means the transfer completes
  assign access = apb_req_i.psel & apb_req_i.penable;
  assign wr_en  = access & pready_o & apb_req_i.pwrite;
  assign div_wr = wr_en & ((apb_req_i.paddr == ATM_OFS_DIV_HI) |
                           (apb_req_i.paddr == ATM_OFS_DIV_LO));

  // Handshake sequencer
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      bus_q     <= ATM_IDLE;
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      case (bus_q)
        ATM_IDLE: begin
          if (access) begin
            bus_q     <= ATM_ACK;
            pready_o  <= 1'b1;
            prdata_o  <= apb_req_i.pwrite ? 32'h0000_0000 : rdata;
            pslverr_o <= ~mapped;
          end
        end
        ATM_ACK: begin
          bus_q     <= ATM_IDLE;
          pready_o  <= 1'b0;
          pslverr_o <= 1'b0;
        end
        default: begin
          bus_q    <= ATM_IDLE;
          pready_o <= 1'b0;
        end
      endcase
    end
  end

  // Read mux; unused upper bits are zero
  always_comb begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    case (apb_req_i.paddr)
      ATM_OFS_DIV_HI:  rdata[1:0] = divisor_q[9:8];
      ATM_OFS_DIV_LO:  rdata[7:0] = divisor_q[7:0];
      ATM_OFS_MISS_HI: rdata[7:0] = delay_q[15:8];
      ATM_OFS_MISS_LO: rdata[7:0] = delay_q[7:0];
      ATM_OFS_IVL_HI:  rdata[7:0] = {rollover_q, interval_q[14:8]};
      ATM_OFS_IVL_LO:  rdata[7:0] = interval_q[7:0];
      ATM_OFS_PHS_HI:  rdata[1:0] = phase_q[9:8];
      ATM_OFS_PHS_LO:  rdata[7:0] = phase_q[7:0];
      ATM_OFS_IRQ_EN:  rdata[2:0] = irq_en_q;
      ATM_OFS_CTRL:    rdata[1:0] = ctrl_q;
      ATM_OFS_STATUS:  rdata[3:0] = {valid, flags_q};
      default:         mapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // Software-written settings
  // ****************************************************************

  // Divisor and delay carry no reset so they survive soft resets
  always_ff @(posedge core_clk_i) begin
    if (wr_en) begin
      case (apb_req_i.paddr)
        ATM_OFS_DIV_HI:  divisor_q[9:8] <= apb_req_i.pwdata[1:0];
        ATM_OFS_DIV_LO:  divisor_q[7:0] <= wbyte(apb_req_i.pwdata);
        ATM_OFS_MISS_HI: delay_q[15:8]  <= wbyte(apb_req_i.pwdata);
        ATM_OFS_MISS_LO: delay_q[7:0]   <= wbyte(apb_req_i.pwdata);
        default: ;
      endcase
    end
  end

  // Interrupt enables and control, cleared at every reset
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      irq_en_q <= ATM_IRQ_EN_RST;
      ctrl_q   <= ATM_CTRL_RST;
    end else if (wr_en && apb_req_i.paddr == ATM_OFS_IRQ_EN) begin
      irq_en_q <= apb_req_i.pwdata[2:0];
    end else if (wr_en && apb_req_i.paddr == ATM_OFS_CTRL) begin
      ctrl_q   <= apb_req_i.pwdata[1:0];
    end
  end

  // ****************************************************************
  // Interval measurement
  // ****************************************************************

  // Rising edge of the pulse input while the timer runs
  assign edge_seen = ctrl_q[ATM_BIT_ENABLE] & pulse_i & ~pulse_q;

  // Interval counter, latch and rollover tracking
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pulse_q    <= 1'b0;
      count_q    <= '0;
      interval_q <= '0;
      roll_run_q <= 1'b0;
      rollover_q <= 1'b0;
    end else begin
      pulse_q <= pulse_i;
      if (edge_seen) begin
        interval_q <= count_q;
        rollover_q <= roll_run_q;
        count_q    <= '0;
        roll_run_q <= 1'b0;
      end else if (ctrl_q[ATM_BIT_ENABLE]) begin
        count_q <= count_q + 1'b1;
        if (&count_q) begin
          roll_run_q <= 1'b1;
        end
      end
    end
  end

  // Valid once two edges passed since reset or a divisor write
  always_ff @(posedge core_clk_i) begin
    if (reset_i || div_wr) begin
      edges_q <= 2'h0;
    end else if (edge_seen && edges_q != ATM_VALID_EDGES) begin
      edges_q <= edges_q + 2'h1;
    end
  end
  assign valid = (edges_q == ATM_VALID_EDGES);

  // ****************************************************************
  // Phase counter: divisor+1 steps spread over one interval
  // ****************************************************************

  // Accumulator avoids a divider at the cost of step jitter
  assign acc_sum    = acc_q + {{(IVL_W+1-DIV_W){1'b0}}, divisor_q} +
                      {{IVL_W{1'b0}}, 1'b1};
  assign phase_tick = ctrl_q[ATM_BIT_ENABLE] & ~edge_seen &
                      (acc_sum >= {1'b0, interval_q}) & (|interval_q);

  always_ff @(posedge core_clk_i) begin
    if (reset_i || edge_seen) begin
      acc_q   <= '0;
      phase_q <= '0;
    end else if (phase_tick) begin
      acc_q   <= acc_sum - {1'b0, interval_q};
      phase_q <= phase_q + 1'b1;
    end else if (ctrl_q[ATM_BIT_ENABLE]) begin
      acc_q   <= acc_sum;
    end
  end

  // ****************************************************************
  // Missing pulse detection
  // ****************************************************************

  // Signed distance of the running count past the last interval
  assign diff      = 16'({1'b0, count_q}) - 16'({1'b0, interval_q});
  assign adapt_lim = {2'b00, interval_q} + {3'b000, interval_q[IVL_W-1:1]};
  assign miss_hit  = ctrl_q[ATM_BIT_ENABLE] & ~edge_seen & ~missed_q &
                     (ctrl_q[ATM_BIT_ADAPT]
                      ? ({2'b00, count_q} == adapt_lim)
                      : (diff == delay_q));

  // One detection per interval, rearmed by the next edge
  always_ff @(posedge core_clk_i) begin
    if (reset_i || edge_seen) begin
      missed_q <= 1'b0;
    end else if (miss_hit) begin
      missed_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Event flags, interrupt requests and outputs
  // ****************************************************************

  assign events = {phase_tick & valid, miss_hit & valid, edge_seen};

  // Sticky flags; a write of zero clears, a new event wins
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      flags_q <= 3'h0;
    end else if (wr_en && apb_req_i.paddr == ATM_OFS_STATUS) begin
      flags_q <= (flags_q & apb_req_i.pwdata[2:0]) | events;
    end else begin
      flags_q <= flags_q | events;
    end
  end

  // Phase and absent-edge outputs held off until the measurement is valid again
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      irq_o         <= 3'h0;
      phase_clk_o   <= 1'b0;
      absent_edge_o <= 1'b0;
    end else begin
      irq_o         <= flags_q & irq_en_q;
      phase_clk_o   <= phase_tick & valid & ~div_wr;
      absent_edge_o <= missed_q & valid & ~div_wr;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  bus_ready_a: assert property (access && !pready_o |=> pready_o)
    else $error("ready did not follow access phase");
  irq_gate_a: assert property (
    irq_o == $past(flags_q & irq_en_q))
    else $error("irq not flag and enable");
  div_valid_a: assert property (div_wr |=> !valid [*2])
    else $error("valid not cleared by divisor write");
  out_inhibit_a: assert property (!valid |=> !phase_clk_o)
    else $error("phase output while invalid");
  miss_sticky_a: assert property (
    flags_q[ATM_BIT_MISS] && !wr_en |=> flags_q[ATM_BIT_MISS])
    else $error("missing flag dropped");
  // Recomputed in plain signed int arithmetic, the compare included, with delay taken as signed
  miss_fixed_a: assert property (
    !ctrl_q[ATM_BIT_ADAPT] && miss_hit |->
    int'(count_q) - int'(interval_q) == int'($signed(delay_q)))
    else $error("fixed miss at wrong count");
  ivl_latch_a: assert property (
    edge_seen |=> interval_q == $past(count_q) && count_q == '0)
    else $error("interval not latched");
  roll_flag_a: assert property (
    edge_seen && roll_run_q |=> rollover_q)
    else $error("rollover not reported");
  en_zero_a: assert property (
    $fell(reset_i) |-> irq_en_q == ATM_IRQ_EN_RST)
    else $error("enables not cleared");
  rd_upper_a: assert property (
    pready_o |-> prdata_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  phase_step_a: assert property (
    phase_tick |=> phase_q == $past(phase_q) + 10'h001)
    else $error("phase count did not step");
  // Adaptive limit checked as 2*count = 3*interval - lsb, no shifts
  miss_adapt_a: assert property (
    ctrl_q[ATM_BIT_ADAPT] && miss_hit |->
    2 * int'(count_q) == 3 * int'(interval_q) - int'(interval_q[0]))
    else $error("adaptive miss at wrong count");

  // Each enable gates only its own request line
  irq_phs_a: assert property (
    !irq_en_q[ATM_BIT_PHS] |=> !irq_o[ATM_BIT_PHS])
    else $error("phase irq while disabled");
  irq_miss_a: assert property (
    !irq_en_q[ATM_BIT_MISS] |=> !irq_o[ATM_BIT_MISS])
    else $error("missing irq while disabled");
  irq_ivl_a: assert property (
    !irq_en_q[ATM_BIT_IVL] |=> !irq_o[ATM_BIT_IVL])
    else $error("interval irq while disabled");

  // Main scenarios: revalidation, misses, interrupts, wrap, absent output
  valid_cov: cover property (div_wr ##[1:200] valid);
  miss_cov: cover property (miss_hit && valid);
  irq_cov: cover property (|irq_o);
  roll_cov: cover property (edge_seen && roll_run_q);
  absent_cov: cover property (absent_edge_o && irq_o[ATM_BIT_MISS]);

endmodule : atm_top

// ==== verif/atm_pulse_src.sv ====
// Rotation pulse source standing in for the sensor beside the timer
`timescale 1ns/1ps

module atm_pulse_src (
  // Clock
  input  wire logic        clk_i,
  // Pulse spacing in clock cycles, zero holds the line low
  input  wire logic [16:0] period_i,
  // Pulse line, actively driven at all times
  output logic             pulse_o
);
  logic [16:0] cnt_q = 17'h0;

  initial pulse_o = 1'b0;

  // One-cycle pulse per period; stopping clears the count so a restart
  // waits a whole period, as a wheel spinning up would
  always @(posedge clk_i) begin
    if (period_i == 17'h0) begin
      cnt_q   <= 17'h0;
      pulse_o <= 1'b0;
    end else begin
      // A shorter new spacing fires at once instead of waiting for a wrap
      pulse_o <= (cnt_q >= period_i - 17'h1);
      cnt_q   <= (cnt_q >= period_i - 17'h1) ? 17'h0 : cnt_q + 17'h1;
    end
  end
endmodule : atm_pulse_src

// ==== verif/testbench.sv ====
// Self-checking bench for the angular timer measurement registers
`timescale 1ns/1ps

module testbench;
  import atm_pkg::*;
  // ****************************************************************
  // Signals and bookkeeping
  // ****************************************************************
  logic         clk, rst, pready, perr, pslverr, phase_clk, absent, pulse;
  logic [31:0]  prdata, rdat;
  logic [2:0]   irq;
  logic [16:0]  period;
  atm_apb_req_t req;
  int           miscompares = 0, n_checks = 0, cyc = 0, last_p = 0;
  int           ph_cnt = 0, ph_last = 0, gap;

  atm_top DUT (.core_clk_i(clk), .reset_i(rst), .apb_req_i(req),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .pulse_i(pulse), .phase_clk_o(phase_clk), .absent_edge_o(absent),
    .irq_o(irq));
  atm_pulse_src src (.clk_i(clk), .period_i(period), .pulse_o(pulse));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cycle stamp of the last pulse and phase steps seen per interval
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pulse === 1'b1) begin
      last_p  <= cyc;
      // The last step of an interval shows on the pulse edge itself
      ph_last <= ph_cnt + ((phase_clk === 1'b1) ? 1 : 0);
      ph_cnt  <= 0;
    end else if (phase_clk === 1'b1) ph_cnt <= ph_cnt + 1;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // APB transfer; the request holds until pready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("FAIL %0t no ready from the slave", $time);
    end
    rdat = prdata;
    perr = pslverr;
    req <= '0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  // Waits a bounded time for the absent-edge output, then gives the gap
  task automatic wait_absent();
    int n;
    n = 0;
    while (absent !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (absent !== 1'b1) begin
      miscompares++;
      $display("FAIL %0t absent edge output never rose", $time);
    end
    gap = cyc - last_p;
  endtask : wait_absent

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_vals();
    rd(ATM_OFS_IRQ_EN, 32'h0);
    bus(1'b1, ATM_OFS_DIV_LO, 32'h5A);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(ATM_OFS_DIV_LO, 32'h5A);
    $display("test reset_vals done");
  endtask : t_reset_vals

  task automatic t_regs();
    bus(1'b1, ATM_OFS_DIV_HI, 32'hFF);
    rd(ATM_OFS_DIV_HI, 32'h3);
    bus(1'b1, ATM_OFS_MISS_HI, 32'hFFA5);
    rd(ATM_OFS_MISS_HI, 32'hA5);
    bus(1'b1, ATM_OFS_MISS_LO, 32'h3C);
    rd(ATM_OFS_MISS_LO, 32'h3C);
    bus(1'b1, ATM_OFS_IRQ_EN, 32'hFF);
    rd(ATM_OFS_IRQ_EN, 32'h7);
    bus(1'b1, ATM_OFS_PHS_HI, 32'hFF);
    rd(ATM_OFS_PHS_HI, 32'h0);
    bus(1'b1, ATM_OFS_IVL_LO, 32'hFF);
    rd(ATM_OFS_IVL_LO, 32'h0);
    bus(1'b0, 8'h3C, 32'h0);
    chk({31'h0, perr}, 32'h1);
    $display("test regs done");
  endtask : t_regs

  task automatic t_measure();
    int n;
    bus(1'b1, ATM_OFS_DIV_HI, 32'h0);
    bus(1'b1, ATM_OFS_DIV_LO, 32'h3);
    bus(1'b1, ATM_OFS_IRQ_EN, 32'h1);
    bus(1'b1, ATM_OFS_CTRL, 32'h1);
    period <= 17'h28;
    repeat (20) @(posedge clk);
    rd(ATM_OFS_STATUS, 32'h0);
    repeat (140) @(posedge clk);
    bus(1'b0, ATM_OFS_STATUS, 32'h0);
    chk(rdat & 32'h8, 32'h8);
    rd(ATM_OFS_IVL_HI, 32'h0);
    // Counter restarts at zero on the edge cycle: 40 cycles read as 39
    rd(ATM_OFS_IVL_LO, 32'h27);
    chk(ph_last, 32'h4);
    chk({29'h0, irq}, 32'h1);
    bus(1'b1, ATM_OFS_DIV_LO, 32'h3);
    bus(1'b0, ATM_OFS_STATUS, 32'h0);
    chk(rdat & 32'h8, 32'h0);
    n = 0;
    // Under two input cycles fit in this span, so no phase step may show
    repeat (35) begin
      @(posedge clk);
      if (phase_clk === 1'b1) n++;
    end
    chk(n, 32'h0);
    $display("test measure done");
  endtask : t_measure

  task automatic t_missing();
    bus(1'b1, ATM_OFS_MISS_HI, 32'h0);
    bus(1'b1, ATM_OFS_MISS_LO, 32'h5);
    bus(1'b1, ATM_OFS_IRQ_EN, 32'h3);
    repeat (100) @(posedge clk);
    period <= 17'h0;
    wait_absent();
    chk({31'h0, gap inside {[45:48]}}, 32'h1);
    repeat (20) @(posedge clk);
    chk({29'h0, irq}, 32'h3);
    bus(1'b0, ATM_OFS_STATUS, 32'h0);
    chk(rdat & 32'h2, 32'h2);
    bus(1'b1, ATM_OFS_STATUS, 32'h0);
    repeat (3) @(posedge clk);
    chk({29'h0, irq}, 32'h0);
    bus(1'b1, ATM_OFS_CTRL, 32'h3);
    period <= 17'h28;
    repeat (150) @(posedge clk);
    period <= 17'h0;
    wait_absent();
    chk({31'h0, gap inside {[60:63]}}, 32'h1);
    $display("test missing done");
  endtask : t_missing

  task automatic t_rollover();
    bus(1'b1, ATM_OFS_CTRL, 32'h1);
    period <= 17'h28;
    repeat (50) @(posedge clk);
    // A spacing beyond the fifteen-bit counter forces a wrap
    period <= 17'h80E8;
    repeat (33100) @(posedge clk);
    bus(1'b0, ATM_OFS_IVL_HI, 32'h0);
    chk(rdat & 32'h80, 32'h80);
    period <= 17'h28;
    repeat (100) @(posedge clk);
    rd(ATM_OFS_IVL_HI, 32'h0);
    $display("test rollover done");
  endtask : t_rollover

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    rst = 1'b1;
    req = '0;
    period = 17'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals();
    t_regs();
    t_measure();
    t_missing();
    t_rollover();
    results();
  end

  // The run needs some 35000 cycles; this cuts a hang well after that
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    $display("FAIL %0t watchdog expired", $time);
    results();
  end
endmodule : testbench
